// ---- pcs_pkg.sv ----
// Purpose: shared constants and types for the card socket control block
// Assumes: 50 MHz ref_clk; one socket per instance
// Notes: strobe timing counts are in ref_clk cycles

package pcs_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 100;
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CARD_BUS_CLOCK_DIV_FAST = 1;
  localparam logic [3:0] CARD_BUS_CLOCK_HALF_FAST = 4'h1;
  localparam logic [3:0] CARD_BUS_CLOCK_HALF_SLOW = 4'h8;
  localparam logic [3:0] CLKRUN_WARN_CYC = 4'h4;
  // cycles our own clock run drive still echoes through the synchroniser
  localparam logic [1:0] SYNC_HOLD_CYC = 2'h2;

  // ------------------------------------------------------------------
  // reset values and encodings
  // ------------------------------------------------------------------
  localparam logic STROBE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    PCS_CYC_MEM_RD,
    PCS_CYC_MEM_WR,
    PCS_CYC_IO_RD,
    PCS_CYC_IO_WR
  } pcs_cyc_t;

  typedef enum logic [1:0] {
    PCS_VOLT_5V,
    PCS_VOLT_3V3,
    PCS_VOLT_XV,
    PCS_VOLT_YV
  } pcs_volt_t;

  // host side request towards the 16-bit card
  typedef struct packed {
    pcs_cyc_t kind;
    logic attr;
    logic even_en;
    logic odd_en;
  } pcs_req_t;

  // 16-bit card strobes, all active low
  typedef struct packed {
    logic attr_sel_n;
    logic out_en_n;
    logic write_en_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic even_byte_select_n;
    logic odd_byte_select_n;
  } pcs_strb_t;

  localparam pcs_strb_t STRB_IDLE = '{default: STROBE_IDLE};

endpackage

// ---- pcs_socket_ctrl.sv ----
// Purpose: one socket's 16-bit strobes and card bus system signals
// Assumes: card_clock_run_n, wait and sense pins are asynchronous
// Notes: card type selects the role of shared pins
//
// Operation
// - attribute select stays high for every common memory access
// - attribute select with memory strobe hits attribute memory, io strobe io
// - socket reset output hard resets the 16-bit card
// - card wait stretches the cycle; controller holds completion meanwhile
// - write enable pulses to latch memory write data
// - card voltage derived from both sense lines together
// - card bus signals sampled on card clock rising edge, listed exceptions
// - card clock at host rate, may slow or stop low
// - controller warns on clock run before slowing card clock
// - card returns to initial state while card bus reset asserted
// - during card bus reset card floats, controller drives valid levels
// - reset asserts anytime, releases synchronous to card clock
// - output enable low for memory reads
// - io read strobe asserted for io reads
// - io write strobe low for io writes
// - first byte select even bytes, second odd bytes

module pcs_socket_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic card_is_cardbus,
  input wire logic req_valid,
  output logic req_ready,
  input wire pcs_pkg::pcs_req_t req,
  output logic req_done,
  input wire logic socket_reset_req,
  input wire logic slow_clock_req,
  input wire logic stop_clock_req,
  output pcs_pkg::pcs_strb_t strb,
  output logic card_reset,
  input wire logic card_wait_n,
  input wire logic protect_or_wide,
  output logic write_protected,
  output logic io_port_wide,
  input wire logic voltage_sense_one,
  input wire logic voltage_sense_two,
  output pcs_pkg::pcs_volt_t card_voltage,
  output logic card_bus_clock,
  output logic card_bus_reset_n,
  input wire logic card_clock_run_n_in,
  output logic card_clock_run_n_out,
  output logic card_clock_run_n_oe,
  output logic card_clock_fast_req
);

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  wire logic [4:0] raw_in = {card_wait_n, protect_or_wide,
    voltage_sense_one, voltage_sense_two, card_clock_run_n_in};

  // two stages; nothing reads stage one except stage two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire logic wait_s_n = sync2_q[4];
  wire logic prot_s = sync2_q[3];
  wire logic vs1_s = sync2_q[2];
  wire logic vs2_s = sync2_q[1];
  wire logic run_s_n = sync2_q[0];

  // ------------------------------------------------------------------
  // 16-bit cycle engine
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_WAIT, ST_DONE} pcs_st_t;
  pcs_st_t st_q, st_d;
  pcs_pkg::pcs_req_t cur_q;
  logic [3:0] cnt_q;
  pcs_pkg::pcs_strb_t strb_q, strb_d;

  wire logic pc16_mode = !card_is_cardbus;
  wire logic take = req_valid && req_ready;
  wire logic cnt_end = (cnt_q == 4'h0);
  assign req_ready = (st_q == ST_IDLE) && pc16_mode && !card_reset;
  assign req_done = (st_q == ST_DONE);

  // next state; wait holds the strobe until released
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (take) st_d = ST_STROBE;
      ST_STROBE: if (cnt_end) st_d = ST_WAIT;
      ST_WAIT: if (wait_s_n) st_d = ST_DONE;
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // strobe decode from the incoming request, registered on acceptance
  wire logic is_mem = (req.kind == pcs_pkg::PCS_CYC_MEM_RD) ||
    (req.kind == pcs_pkg::PCS_CYC_MEM_WR);
  always_comb begin
    strb_d = strb_q;
    if (take) begin
      strb_d = pcs_pkg::STRB_IDLE;
      strb_d.attr_sel_n = !(req.attr || !is_mem);
      strb_d.out_en_n = (req.kind != pcs_pkg::PCS_CYC_MEM_RD);
      strb_d.write_en_n = (req.kind != pcs_pkg::PCS_CYC_MEM_WR);
      strb_d.io_read_strobe_n = (req.kind != pcs_pkg::PCS_CYC_IO_RD);
      strb_d.io_write_strobe_n = (req.kind != pcs_pkg::PCS_CYC_IO_WR);
      strb_d.even_byte_select_n = !req.even_en;
      strb_d.odd_byte_select_n = !req.odd_en;
    end else if (st_q == ST_WAIT && wait_s_n) begin
      strb_d = pcs_pkg::STRB_IDLE;
    end
  end

  // state, request and strobe registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      strb_q <= pcs_pkg::STRB_IDLE;
      cur_q <= '0;
    end else begin
      st_q <= st_d;
      strb_q <= strb_d;
      if (take) cur_q <= req;
      if (take) cnt_q <= pcs_pkg::STROBE_CYC - 4'h1;
      else if (!cnt_end) cnt_q <= cnt_q - 4'h1;
    end
  end
  assign strb = strb_q;

  // ------------------------------------------------------------------
  // sense lines and shared protect input
  // ------------------------------------------------------------------
  logic wp_q, wide_q, rst16_q;
  pcs_pkg::pcs_volt_t volt_q;
  wire logic io_cyc = (cur_q.kind == pcs_pkg::PCS_CYC_IO_RD) ||
    (cur_q.kind == pcs_pkg::PCS_CYC_IO_WR);

  // both sense lines decoded as one pair, never separately
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_q <= pcs_pkg::PCS_VOLT_5V;
      wp_q <= 1'b0;
      wide_q <= 1'b0;
      rst16_q <= 1'b1;
    end else begin
      volt_q <= pcs_pkg::pcs_volt_t'({vs2_s, vs1_s});
      wp_q <= pc16_mode && !io_cyc && prot_s;
      wide_q <= pc16_mode && io_cyc && st_q != ST_IDLE && !prot_s;
      rst16_q <= pc16_mode && socket_reset_req;
    end
  end
  assign card_voltage = volt_q;
  assign write_protected = wp_q;
  assign io_port_wide = wide_q;
  assign card_reset = rst16_q;

  // ------------------------------------------------------------------
  // card bus clock, clock run and reset
  // ------------------------------------------------------------------
  logic [3:0] div_q, warn_q;
  logic card_bus_clock_q, slow_q, card_bus_reset_n_n_q, card_bus_reset_n_req_q, run_oe_q, fast_q;
  logic [1:0] hold_q;
  wire logic want_slow = slow_clock_req && run_s_n;
  // our own low drive lingers in the synchroniser after release; without
  // the holdoff it would read as a card request and undo the slowdown
  wire logic card_pull = !run_s_n && !run_oe_q && (hold_q == 2'h0);
  wire logic [3:0] half = slow_q ? pcs_pkg::CARD_BUS_CLOCK_HALF_SLOW :
    pcs_pkg::CARD_BUS_CLOCK_HALF_FAST;
  wire logic div_end = (div_q >= half - 4'h1);
  wire logic stopped = stop_clock_req && !card_bus_clock_q && run_s_n;
  wire logic card_bus_clock_rise = div_end && !card_bus_clock_q && !stopped;

  // clock runs at host rate unless slowed after a warning or stopped low on request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      card_bus_clock_q <= 1'b0;
      slow_q <= 1'b0;
      warn_q <= 4'h0;
      run_oe_q <= 1'b0;
      fast_q <= 1'b0;
      hold_q <= 2'h0;
    end else begin
      div_q <= (div_end || stopped) ? 4'h0 : div_q + 4'h1;
      if (div_end && !stopped) card_bus_clock_q <= !card_bus_clock_q;
      fast_q <= card_is_cardbus && card_pull;
      if (card_pull) slow_q <= 1'b0;
      if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
      if (want_slow && !slow_q && !run_oe_q) begin
        run_oe_q <= 1'b1;
        warn_q <= pcs_pkg::CLKRUN_WARN_CYC;
      end else if (run_oe_q && warn_q != 4'h0) begin
        warn_q <= warn_q - 4'h1;
      end else if (run_oe_q) begin
        run_oe_q <= 1'b0;
        slow_q <= 1'b1;
        hold_q <= pcs_pkg::SYNC_HOLD_CYC;
      end
    end
  end

  // assert on the next ref_clk edge after the registered request, release only on a card clock rising edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_bus_reset_n_n_q <= 1'b0;
      card_bus_reset_n_req_q <= 1'b1;
    end else begin
      card_bus_reset_n_req_q <= socket_reset_req || !card_is_cardbus;
      if (card_bus_reset_n_req_q) card_bus_reset_n_n_q <= 1'b0;
      else if (card_bus_clock_rise) card_bus_reset_n_n_q <= 1'b1;
    end
  end

  assign card_bus_clock = card_bus_clock_q;
  assign card_bus_reset_n = card_bus_reset_n_n_q;
  assign card_clock_run_n_out = 1'b0;
  assign card_clock_run_n_oe = run_oe_q && card_is_cardbus;
  assign card_clock_fast_req = fast_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence cyc_start_s;
    take;
  endsequence

  common_attr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_start_s and is_mem && !req.attr |=> strb.attr_sel_n)
    else $error("attribute select low in common access");
  io_attr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_start_s and !is_mem |=> !strb.attr_sel_n)
    else $error("attribute select high in io access");
  wait_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q == ST_WAIT && !wait_s_n |=> st_q == ST_WAIT)
    else $error("cycle finished during wait");
  write_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_start_s and req.kind == pcs_pkg::PCS_CYC_MEM_WR
    |=> !strb.write_en_n [*4])
    else $error("write strobe too short");
  oe_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_start_s and req.kind == pcs_pkg::PCS_CYC_MEM_RD
    |=> !strb.out_en_n && strb.write_en_n)
    else $error("output enable missing on read");
  byte_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_start_s |=> strb.even_byte_select_n == !$past(req.even_en))
    else $error("even byte select wrong");
  rst_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(card_bus_reset_n) |-> $rose(card_bus_clock))
    else $error("card reset released off clock edge");
  warn_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(slow_q) |-> $past(run_oe_q))
    else $error("clock slowed without warning");
  io_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_start_s and req.kind == pcs_pkg::PCS_CYC_IO_RD
    |=> !strb.io_read_strobe_n && strb.io_write_strobe_n)
    else $error("io read strobe wrong");

endmodule

// ---- pcs_card_model.sv ----
// Purpose: behavioural card at the socket pins
// Assumes: bench sets wait length and switch states
// Notes: clock run pull is open drain, wired in the bench
module pcs_card_model (
  input wire logic ref_clk,
  input wire pcs_pkg::pcs_strb_t strb,
  input wire logic card_bus_reset_n,
  input wire logic [3:0] wait_len,
  input wire logic wp_sw,
  input wire logic wide_port,
  input wire logic want_fast,
  output logic card_wait_n,
  output logic protect_or_wide,
  output logic clock_run_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  wire logic io_cyc = !(strb.io_read_strobe_n & strb.io_write_strobe_n);
  wire logic mem_cyc = !(strb.out_en_n & strb.write_en_n);
  // counts strobe cycles so wait covers the first wait_len of them
  always @(posedge ref_clk) begin
    if (!(io_cyc | mem_cyc)) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  assign card_wait_n = !((io_cyc | mem_cyc) && cnt_q < wait_len);
  // shared pin: port width ack in io cycles, switch state otherwise
  assign protect_or_wide = io_cyc ? !wide_port : wp_sw;
  // released while card bus reset holds the card
  assign clock_run_pull = want_fast & card_bus_reset_n;
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench for one socket control block
// Assumes: 50 MHz ref_clk, card model on the pins
// Notes: random cycles from a fixed seed, corners mixed in
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_n = 1'b0, card_is_cardbus = 1'b0;
  logic req_valid = 1'b0, socket_reset_req = 1'b0, slow_clock_req = 1'b0;
  logic stop_clock_req = 1'b0, voltage_sense_one = 1'b0;
  logic voltage_sense_two = 1'b0, wp_sw = 1'b0, wide_port = 1'b0;
  logic want_fast = 1'b0, prev_rn = 1'b0, prev_clk = 1'b0;
  logic [3:0] wait_len = 4'h0;
  pcs_pkg::pcs_req_t req = '0;
  pcs_pkg::pcs_strb_t strb, exp_s;
  pcs_pkg::pcs_volt_t card_voltage;
  logic req_ready, req_done, card_reset, card_wait_n, protect_or_wide;
  logic write_protected, io_port_wide, card_bus_clock, card_bus_reset_n;
  logic card_clock_run_n_out, card_clock_run_n_oe, card_clock_fast_req;
  logic clock_run_pull;
  int miscompares = 0, n_checks = 0, cycles = 0, seed = 49571, h;
  // open drain clock run with pull-up
  wire logic cr_pin = (card_clock_run_n_oe ? card_clock_run_n_out : 1'b1)
    & !clock_run_pull;
  always #10 ref_clk = ~ref_clk;
  pcs_socket_ctrl dut (.ref_clk, .rst_n, .card_is_cardbus, .req_valid,
    .req_ready, .req, .req_done, .socket_reset_req, .slow_clock_req,
    .stop_clock_req, .strb, .card_reset, .card_wait_n, .protect_or_wide,
    .write_protected, .io_port_wide, .voltage_sense_one,
    .voltage_sense_two, .card_voltage, .card_bus_clock, .card_bus_reset_n,
    .card_clock_run_n_in(cr_pin), .card_clock_run_n_out,
    .card_clock_run_n_oe, .card_clock_fast_req);
  pcs_card_model card (.ref_clk, .strb, .card_bus_reset_n, .wait_len,
    .wp_sw, .wide_port, .want_fast, .card_wait_n, .protect_or_wide,
    .clock_run_pull);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(int k = 1);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk_bit(logic got, logic exp, string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_strb(pcs_pkg::pcs_strb_t got, pcs_pkg::pcs_strb_t exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: strobes %h", $time, got);
    end
  endtask
  function automatic pcs_pkg::pcs_strb_t exp_strb(pcs_pkg::pcs_req_t r);
    exp_strb = pcs_pkg::STRB_IDLE;
    // io cycles always run with attribute select low
    exp_strb.attr_sel_n = !r.attr && (r.kind == pcs_pkg::PCS_CYC_MEM_RD ||
      r.kind == pcs_pkg::PCS_CYC_MEM_WR);
    exp_strb.out_en_n = r.kind != pcs_pkg::PCS_CYC_MEM_RD;
    exp_strb.write_en_n = r.kind != pcs_pkg::PCS_CYC_MEM_WR;
    exp_strb.io_read_strobe_n = r.kind != pcs_pkg::PCS_CYC_IO_RD;
    exp_strb.io_write_strobe_n = r.kind != pcs_pkg::PCS_CYC_IO_WR;
    exp_strb.even_byte_select_n = !r.even_en;
    exp_strb.odd_byte_select_n = !r.odd_en;
  endfunction
  // one 16-bit cycle, strobes checked every cycle until done
  task automatic run_cycle(int i);
    int n, last_low;
    req = pcs_pkg::pcs_req_t'(5'($random(seed)));
    wait_len = (i == 1) ? 4'hf : (i == 0) ? 4'h0 : 4'($random(seed) & 7);
    wide_port = 1'($random(seed));
    wp_sw = 1'($random(seed));
    exp_s = exp_strb(req);
    n = 0;
    while (!req_ready && n < 50) begin
      tick();
      n++;
    end
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    n = 0;
    last_low = 0;
    while (req_done !== 1'b1 && n < 60) begin
      tick();
      n++;
      if (req_done !== 1'b1) chk_strb(strb, exp_s);
      if (card_wait_n === 1'b0) last_low = n;
      if (n == 5 && exp_s.io_read_strobe_n & exp_s.io_write_strobe_n)
        chk_bit(write_protected, wp_sw, "write protect");
      else if (n == 5) chk_bit(io_port_wide, wide_port, "wide ack");
    end
    if (wait_len == 4'h0)
      chk_bit(n == pcs_pkg::STROBE_CYC + 1, 1'b1, "done time");
    chk_bit(n > last_low && n <= last_low + 7, 1'b1, "wait hold");
    chk_strb(strb, pcs_pkg::STRB_IDLE);
  endtask
  task automatic half_period(output int hp);
    logic v;
    int k;
    v = card_bus_clock;
    k = 0;
    while (card_bus_clock === v && k < 40) begin
      tick();
      k++;
    end
    v = card_bus_clock;
    hp = 0;
    while (card_bus_clock === v && hp < 40) begin
      tick();
      hp++;
    end
  endtask
  // card bus reset may only rise with a card clock rising edge
  always @(posedge ref_clk) begin
    #1;
    if (card_bus_reset_n === 1'b1 && prev_rn === 1'b0)
      chk_bit(card_bus_clock && !prev_clk, 1'b1, "reset release");
    prev_rn = card_bus_reset_n;
    prev_clk = card_bus_clock;
  end
  // hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    rst_n = 1'b1;
    tick(2);
    chk_bit(card_reset, 1'b0, "card reset idle");
    chk_bit(card_bus_reset_n, 1'b0, "bus reset for 16-bit");
    for (int i = 0; i < 40; i++) run_cycle(i);
    for (int i = 0; i < 4; i++) begin
      {voltage_sense_two, voltage_sense_one} = 2'(i);
      tick(4);
      chk_bit(card_voltage === 2'(i), 1'b1, "voltage code");
    end
    socket_reset_req = 1'b1;
    tick(3);
    chk_bit(card_reset, 1'b1, "card reset on");
    chk_bit(req_ready, 1'b0, "refused in reset");
    socket_reset_req = 1'b0;
    card_is_cardbus = 1'b1;
    tick(3);
    chk_bit(card_reset, 1'b0, "card reset off");
    chk_bit(req_ready, 1'b0, "refused for card bus");
    tick(20);
    chk_bit(card_bus_reset_n, 1'b1, "bus reset released");
    half_period(h);
    chk_bit(h == pcs_pkg::CARD_BUS_CLOCK_HALF_FAST, 1'b1, "fast clock");
    want_fast = 1'b1;
    tick(4);
    chk_bit(card_clock_fast_req, 1'b1, "fast request");
    want_fast = 1'b0;
    tick(4);
    chk_bit(card_clock_fast_req, 1'b0, "fast request off");
    slow_clock_req = 1'b1;
    h = 0;
    repeat (20) begin
      tick();
      if (card_clock_run_n_oe === 1'b1 && cr_pin === 1'b0) h++;
    end
    chk_bit(h == pcs_pkg::CLKRUN_WARN_CYC + 1, 1'b1, "slow warning");
    half_period(h);
    chk_bit(h == pcs_pkg::CARD_BUS_CLOCK_HALF_SLOW, 1'b1, "slow clock");
    // card asks for speed again while slowed
    want_fast = 1'b1;
    slow_clock_req = 1'b0;
    tick(4);
    chk_bit(card_clock_fast_req, 1'b1, "fast request when slow");
    half_period(h);
    chk_bit(h == pcs_pkg::CARD_BUS_CLOCK_HALF_FAST, 1'b1, "clock sped up");
    want_fast = 1'b0;
    stop_clock_req = 1'b1;
    tick(20);
    repeat (12) begin
      tick();
      chk_bit(card_bus_clock, 1'b0, "stopped low");
    end
    socket_reset_req = 1'b1;
    tick(3);
    chk_bit(card_bus_reset_n, 1'b0, "bus reset on");
    report_and_stop();
  end
endmodule
